/* File: inc/ocf_pkg.sv */
/*
 Constants for the overcurrent and internal overtemperature fault response block:
 command codes, field positions, status bit positions, reset values and timing.
 Assumes a 20 MHz device clock.
*/
package ocf_pkg;
   // Command codes
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OC_ACTION = 8'h47;
   localparam logic [7:0] CMD_OT_ACTION = 8'hD6;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
   localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
   localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
   // Reset values
   localparam logic [7:0] OC_ACTION_RESET = 8'h00;
   localparam logic [7:0] OT_ACTION_RESET = 8'hC0;
   // Response byte fields
   localparam int RESP_MSB = 7;
   localparam int RESP_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;
   localparam logic [1:0] RESP_LIMIT_ON = 2'b00;
   localparam logic [1:0] RESP_UNSUP = 2'b01;
   localparam logic [1:0] RESP_DEGLITCH = 2'b10;
   localparam logic [1:0] RESP_OFF_NOW = 2'b11;
   localparam logic [1:0] OT_RESP_OFF_RETRY = 2'b10;
   localparam logic [1:0] OT_RESP_WHILE = 2'b11;
   localparam logic [2:0] RETRY_NONE = 3'b000;
   localparam logic [2:0] RETRY_FOREVER = 3'b111;
   // Status bit positions
   localparam int SB_NONE_ABOVE = 0;
   localparam int SB_CML = 1;
   localparam int SB_IOUT_OC = 4;
   localparam int SW_MFR = 12;
   localparam int SW_IOUT = 14;
   localparam int SIOUT_OC_FAULT = 7;
   localparam int SCML_FAULT = 6;
   localparam int SMFR_OT_FAULT = 6;
   // Timing
   localparam int CLOCK_HZ = 20_000_000;
   localparam int DELAY_UNIT_MS = 16;
   localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * (CLOCK_HZ / 1000);
   // Output control states
   typedef enum logic [5:0] {
      ST_OFF = 6'b00_0001,
      ST_RUN = 6'b00_0010,
      ST_LIMIT = 6'b00_0100,
      ST_LATCH = 6'b00_1000,
      ST_RETRY = 6'b01_0000,
      ST_OT_WAIT = 6'b10_0000
   } ocf_state_t;
endpackage

/* File: design/ocf_fault_response.sv */
/*
 Fault response control for output overcurrent and internal overtemperature:
 sticky status bits, alert, response byte storage and the output enable state machine.
 Assumes synchronous inputs, an external restart interval timer pulsing restart_tick,
 and a decoded byte-wide command port from the serial interface.
*/
// What this block does
// RULE_01 - Overcurrent fault sets none-above, IOUT_OC, IOUT and overcurrent status bits, alert.
// RULE_02 - Overcurrent response 00 keeps running, current held at limit, indefinitely.
// RULE_03 - Response 10 limits for programmed delay, then applies retry policy if still limiting.
// RULE_04 - Response 11 disables output at once, then follows retry policy.
// RULE_05 - Retry 000 never restarts; output stays off until run_in or operation_on cycled, or reset.
// RULE_06 - Retry 111 restarts forever, spaced by retry interval, until off or other fault.
// RULE_07 - Overcurrent delay field counts units of 16 ms before shutdown.
// RULE_08 - Delay count used only by deglitched response, ignored otherwise.
// RULE_09 - Fault bits stay set until clear command, off-then-on, or power reset.
// RULE_10 - Overtemperature response byte is command 0xD6, default 0xC0.
// RULE_11 - Overtemperature fault sets none-above, MFR and overtemperature status bits, alert.
// RULE_12 - Overtemperature response 00 or 01 written is rejected with a CML fault.
// RULE_13 - Overtemperature response 10 disables output, then follows retry policy.
// RULE_14 - Overtemperature response 11 keeps output off only while fault persists.
// RULE_15 - Overtemperature retry supports only 000; other values raise CML fault.
// RULE_16 - Overtemperature delay bits are ignored.
// RULE_17 - Overcurrent response byte is read/write command 0x47, default 0x00.
// RULE_18 - Host writes only supported codes and treats CML as a rejected write.
`timescale 1ns/1ps
module ocf_fault_response
   import ocf_pkg::*;
#(
   parameter int UNIT_CYCLES = DELAY_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Command port
   input wire logic cmd_write,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_wdata,
   output logic [15:0] rsp_rdata,
   output logic rsp_valid,
   // Fault sensing and control inputs
   input wire logic oc_detect,
   input wire logic ot_detect,
   input wire logic run_in,
   input wire logic operation_on,
   input wire logic restart_tick,
   // Power stage control
   output logic output_enable,
   output logic current_limit,
   // Alert pin, open drain, low when driven
   output logic alert_out,
   output logic alert_oe
);
   ocf_state_t state;
   ocf_state_t next_state;
   logic [7:0] oc_action;
   logic [7:0] ot_action;
   logic oc_flag;
   logic ot_flag;
   logic cml_flag;
   logic en_q;
   logic [31:0] unit_div;
   logic [2:0] unit_cnt;

   function automatic logic is_code(input logic [7:0] code, input logic [7:0] want);
      return code == want;
   endfunction

   wire en = run_in & operation_on;
   wire en_rise = en & ~en_q;
   wire wr_clear = cmd_write & is_code(cmd_code, CMD_CLEAR_FAULTS);
   wire wr_oc = cmd_write & is_code(cmd_code, CMD_OC_ACTION);
   wire wr_ot = cmd_write & is_code(cmd_code, CMD_OT_ACTION);
   wire [1:0] oc_resp = oc_action[RESP_MSB:RESP_LSB];
   wire [2:0] oc_retry = oc_action[RETRY_MSB:RETRY_LSB];
   wire [2:0] oc_delay = oc_action[DELAY_MSB:DELAY_LSB];
   wire [1:0] ot_resp = ot_action[RESP_MSB:RESP_LSB];
   wire [1:0] wr_ot_resp = cmd_wdata[RESP_MSB:RESP_LSB];
   wire [2:0] wr_ot_retry = cmd_wdata[RETRY_MSB:RETRY_LSB];
   // Delay bits of the overtemperature byte are stored and read back but never used
   wire ot_wr_ok = (wr_ot_resp == OT_RESP_OFF_RETRY || wr_ot_resp == OT_RESP_WHILE)
                   && wr_ot_retry == RETRY_NONE; // see RULE_16
   wire ot_wr_bad = wr_ot & ~ot_wr_ok; // see RULE_12 see RULE_15
   wire known_code = is_code(cmd_code, CMD_CLEAR_FAULTS) | is_code(cmd_code, CMD_OC_ACTION)
                     | is_code(cmd_code, CMD_OT_ACTION) | is_code(cmd_code, CMD_STATUS_BYTE)
                     | is_code(cmd_code, CMD_STATUS_WORD) | is_code(cmd_code, CMD_STATUS_IOUT)
                     | is_code(cmd_code, CMD_STATUS_CML) | is_code(cmd_code, CMD_STATUS_MFR);
   wire bad_cmd = (cmd_write | cmd_read) & ~known_code;
   wire out_on = (state == ST_RUN) | (state == ST_LIMIT);
   wire oc_event = en & out_on & oc_detect;
   wire ot_event = en & ot_detect;
   wire fault_clear = wr_clear | en_rise; // see RULE_09
   wire unit_tick = (unit_div == 32'(UNIT_CYCLES - 1));
   wire delay_done = (unit_cnt >= oc_delay); // see RULE_07
   wire oc_retry_off = (oc_retry == RETRY_NONE);

   // Status views
   wire [7:0] status_byte = {3'b000, oc_flag, 2'b00, cml_flag, oc_flag | ot_flag};
   wire [15:0] status_word = {1'b0, oc_flag, 1'b0, ot_flag, 4'h0, status_byte};
   wire [7:0] status_iout = {oc_flag, 7'h00};
   wire [7:0] status_cml = {1'b0, cml_flag, 6'h00};
   wire [7:0] status_mfr = {1'b0, ot_flag, 6'h00};
   wire [15:0] next_rdata =
      is_code(cmd_code, CMD_OC_ACTION) ? {8'h00, oc_action} :
      is_code(cmd_code, CMD_OT_ACTION) ? {8'h00, ot_action} :
      is_code(cmd_code, CMD_STATUS_BYTE) ? {8'h00, status_byte} :
      is_code(cmd_code, CMD_STATUS_WORD) ? status_word :
      is_code(cmd_code, CMD_STATUS_IOUT) ? {8'h00, status_iout} :
      is_code(cmd_code, CMD_STATUS_CML) ? {8'h00, status_cml} :
      is_code(cmd_code, CMD_STATUS_MFR) ? {8'h00, status_mfr} : 16'h0000;

   // Shutdown destination for an overcurrent fault
   wire ocf_state_t oc_off_state = oc_retry_off ? ST_LATCH : ST_RETRY; // see RULE_05 see RULE_06
   // Overtemperature retry only supports no restart
   wire ocf_state_t ot_off_state = (ot_resp == OT_RESP_WHILE) ? ST_OT_WAIT : ST_LATCH; // see RULE_13 see RULE_14

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (en) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ot_detect) begin
               next_state = ot_off_state;
            end else if (oc_detect && oc_resp == RESP_DEGLITCH) begin
               next_state = ST_LIMIT; // see RULE_03
            end else if (oc_detect && oc_resp == RESP_OFF_NOW) begin
               next_state = oc_off_state; // see RULE_04
            end
         end
         ST_LIMIT: begin
            if (ot_detect) begin
               next_state = ot_off_state;
            end else if (!oc_detect) begin
               next_state = ST_RUN;
            end else if (delay_done) begin
               next_state = oc_off_state; // see RULE_03
            end
         end
         ST_LATCH: begin
            next_state = ST_LATCH; // see RULE_05
         end
         ST_RETRY: begin
            if (ot_detect) begin
               next_state = ot_off_state;
            end else if (restart_tick) begin
               next_state = ST_RUN; // see RULE_06
            end
         end
         ST_OT_WAIT: begin
            if (!ot_detect) begin
               next_state = ST_RUN; // see RULE_14
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      if (!en) begin
         next_state = ST_OFF;
      end
   end

   wire next_on = (next_state == ST_RUN) | (next_state == ST_LIMIT);
   // Constant current applies in 00 (and unsupported 01) and during the deglitch delay
   wire next_cur_limit = (next_state == ST_LIMIT)
                         | ((next_state == ST_RUN) & oc_detect
                            & (oc_resp == RESP_LIMIT_ON | oc_resp == RESP_UNSUP)); // see RULE_02

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= ST_OFF;
         output_enable <= 1'b0;
         current_limit <= 1'b0;
         en_q <= 1'b0;
      end else begin
         state <= next_state;
         output_enable <= next_on;
         current_limit <= next_cur_limit;
         en_q <= en;
      end
   end

   // Delay unit divider, restarted on entry to the deglitch state
   always_ff @(posedge clock) begin
      if (!rst_b || state != ST_LIMIT) begin
         unit_div <= '0;
         unit_cnt <= '0;
      end else if (unit_tick) begin
         unit_div <= '0;
         if (unit_cnt != 3'b111) begin
            unit_cnt <= unit_cnt + 3'd1; // see RULE_08
         end
      end else begin
         unit_div <= unit_div + 32'd1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         oc_action <= OC_ACTION_RESET; // see RULE_17
         ot_action <= OT_ACTION_RESET; // see RULE_10
      end else begin
         if (wr_oc) begin
            oc_action <= cmd_wdata;
         end
         if (wr_ot && ot_wr_ok) begin
            ot_action <= cmd_wdata;
         end
      end
   end

   // Sticky flags: a set in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         oc_flag <= 1'b0;
         ot_flag <= 1'b0;
         cml_flag <= 1'b0;
      end else begin
         oc_flag <= oc_event | (oc_flag & ~fault_clear); // see RULE_01 see RULE_09
         ot_flag <= ot_event | (ot_flag & ~fault_clear); // see RULE_11 see RULE_09
         cml_flag <= ot_wr_bad | bad_cmd | (cml_flag & ~fault_clear); // see RULE_12
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         alert_out <= 1'b0;
         alert_oe <= 1'b0;
         rsp_rdata <= 16'h0000;
         rsp_valid <= 1'b0;
      end else begin
         alert_out <= 1'b0;
         alert_oe <= oc_flag | ot_flag | cml_flag; // see RULE_01 see RULE_11
         rsp_valid <= cmd_read;
         if (cmd_read) begin
            rsp_rdata <= next_rdata;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence oc_hit_s;
      en && out_on && oc_detect && !wr_clear && !en_rise;
   endsequence
   sequence flags_shown_s;
      status_byte[SB_IOUT_OC] && status_word[SW_IOUT] && status_iout[SIOUT_OC_FAULT];
   endsequence

   oc_status_set_a: assert property (oc_hit_s |=> flags_shown_s ##1 alert_oe) // see RULE_01
      else $error("overcurrent status or alert missing");
   ot_status_set_a: assert property (ot_event |=> status_word[SW_MFR] // see RULE_11
      && status_mfr[SMFR_OT_FAULT] && status_byte[SB_NONE_ABOVE] ##1 alert_oe)
      else $error("overtemperature status or alert missing");
   cc_mode_run_a: assert property (state == ST_RUN && en && oc_detect && !ot_detect // see RULE_02
      && oc_resp == RESP_LIMIT_ON |=> state == ST_RUN && output_enable && current_limit)
      else $error("constant current mode left running state");
   off_now_a: assert property (state == ST_RUN && en && oc_detect && !ot_detect // see RULE_04
      && oc_resp == RESP_OFF_NOW |=> !output_enable)
      else $error("immediate overcurrent shutdown missing");
   latch_hold_a: assert property (state == ST_LATCH && en [*2] |-> !output_enable && state == ST_LATCH) // see RULE_05
      else $error("latched off state restarted");
   retry_start_a: assert property (state == ST_RETRY && en // see RULE_06
      && !ot_detect && restart_tick |=> state == ST_RUN && output_enable)
      else $error("restart after interval missing");
   limit_zero_a: assert property (state == ST_LIMIT && en // see RULE_03 see RULE_07
      && oc_detect && !ot_detect && oc_delay == 3'd0 |=> !output_enable)
      else $error("zero delay deglitch did not shut down");
   limit_hold_a: assert property (state == ST_LIMIT && en // see RULE_08
      && oc_detect && !ot_detect && unit_cnt < oc_delay |=> output_enable && current_limit)
      else $error("deglitch ended before delay");
   ot_reject_a: assert property (wr_ot && !ot_wr_ok |=> cml_flag && ot_action == $past(ot_action)) // see RULE_12 see RULE_15
      else $error("unsupported overtemperature write accepted");
   ot_resume_a: assert property (state == ST_OT_WAIT && en && !ot_detect |=> output_enable) // see RULE_14
      else $error("output not resumed after overtemperature");
   oc_sticky_a: assert property (oc_flag && !fault_clear |=> oc_flag) // see RULE_09
      else $error("overcurrent flag lost without clear");
   oc_write_a: assert property (wr_oc |=> oc_action == $past(cmd_wdata)) // see RULE_17
      else $error("overcurrent response write lost");
   ot_accept_a: assert property (wr_ot && ot_wr_ok // see RULE_16
      |=> ot_action == $past(cmd_wdata))
      else $error("supported overtemperature write not stored");
   flag_clear_a: assert property (fault_clear && !oc_event |=> !oc_flag) // see RULE_09
      else $error("overcurrent flag survived clear");
   ot_latch_a: assert property (state == ST_RUN && en && ot_detect // see RULE_13
      && ot_resp == OT_RESP_OFF_RETRY |=> state == ST_LATCH && !output_enable)
      else $error("overtemperature shutdown missing");
   ot_wait_hold_a: assert property (state == ST_OT_WAIT && en && ot_detect // see RULE_14
      |=> state == ST_OT_WAIT && !output_enable)
      else $error("output resumed while overtemperature present");
   retry_wait_a: assert property (state == ST_RETRY && en // see RULE_06
      && !ot_detect && !restart_tick |=> state == ST_RETRY && !output_enable)
      else $error("restart before interval");
   limit_exit_a: assert property (state == ST_LIMIT && en // see RULE_03
      && !oc_detect && !ot_detect |=> state == ST_RUN && output_enable)
      else $error("deglitch state kept after overcurrent cleared");
   ot_retry_bad_a: assert property (wr_ot && wr_ot_retry != RETRY_NONE |=> cml_flag) // see RULE_15
      else $error("unsupported overtemperature retry accepted");
endmodule

/* File: testbench/ocf_host_model.sv */
/*
 Host model for the command port: byte writes and byte or word reads.
 Assumes the device samples requests on the rising clock edge.
*/
`timescale 1ns/1ps
module ocf_host_model (
   // Clock
   input wire logic clock,
   // Requests toward the device
   output logic cmd_write,
   output logic cmd_read,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_wdata,
   // Answers from the device
   input wire logic [15:0] rsp_rdata,
   input wire logic rsp_valid
);
   initial begin
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 8'h00;
   end

   // Released strobes go low; code and data lines show the inverse of the last value
   task automatic release_lines();
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      cmd_code = ~cmd_code;
      cmd_wdata = ~cmd_wdata;
   endtask

   task automatic wr(input logic [7:0] code, input logic [7:0] data);
      @(negedge clock);
      cmd_code = code;
      cmd_wdata = data;
      cmd_write = 1'b1;
      @(negedge clock);
      release_lines();
   endtask

   task automatic rd(input logic [7:0] code, output logic [15:0] data);
      int n;
      @(negedge clock);
      cmd_code = code;
      cmd_read = 1'b1;
      @(negedge clock);
      release_lines();
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4) begin
         @(negedge clock);
         n++;
      end
      data = (rsp_valid === 1'b1) ? rsp_rdata : 16'hxxxx;
   endtask
endmodule

/* File: testbench/tb_overcurrent_overtemp_fault_response.sv */
/*
 Self-checking bench for the fault response block, driven through the host model.
 Assumes a 20 MHz clock and the delay unit shortened to 8 cycles.
*/
`timescale 1ns/1ps
module tb_overcurrent_overtemp_fault_response;
   import ocf_pkg::*;
   localparam logic [15:0] SW_MASK = 16'h5013;
   logic clock = 1'b0, rst_b = 1'b0, cmd_write, cmd_read, rsp_valid;
   logic [7:0] cmd_code, cmd_wdata;
   logic [15:0] rsp_rdata;
   logic oc_detect = 1'b0, ot_detect = 1'b0, run_in = 1'b0, operation_on = 1'b1;
   logic restart_tick = 1'b0, output_enable, current_limit, alert_out, alert_oe;
   int n_mismatch = 0, checks_done = 0;

   always #25 clock = ~clock;

   ocf_fault_response #(.UNIT_CYCLES(8)) dut_u (.clock(clock), .rst_b(rst_b),
      .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
      .oc_detect(oc_detect), .ot_detect(ot_detect), .run_in(run_in),
      .operation_on(operation_on), .restart_tick(restart_tick),
      .output_enable(output_enable), .current_limit(current_limit),
      .alert_out(alert_out), .alert_oe(alert_oe));

   ocf_host_model host_u (.clock(clock), .cmd_write(cmd_write), .cmd_read(cmd_read),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_rdata(rsp_rdata),
      .rsp_valid(rsp_valid));

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic bit_chk(input logic seen, input logic exp);
      chk({15'h0000, seen}, {15'h0000, exp});
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] code, input logic [15:0] mask,
                         input logic [15:0] exp);
      logic [15:0] v;
      host_u.rd(code, v);
      chk(v & mask, exp);
   endtask

   task automatic setup(input logic [7:0] oc_act, input logic [7:0] ot_act);
      run_in = 1'b0;
      cycles(2);
      host_u.wr(CMD_OC_ACTION, oc_act);
      host_u.wr(CMD_OT_ACTION, ot_act);
      host_u.wr(CMD_CLEAR_FAULTS, 8'h00);
      run_in = 1'b1;
      cycles(3);
   endtask

   task automatic tick();
      restart_tick = 1'b1;
      cycles(1);
      restart_tick = 1'b0;
      cycles(2);
   endtask

   task automatic reg_defaults();
      rd_chk(CMD_OC_ACTION, 16'hffff, 16'h0000);
      rd_chk(CMD_OT_ACTION, 16'hffff, 16'h00c0);
      host_u.wr(CMD_OC_ACTION, 8'hab);
      rd_chk(CMD_OC_ACTION, 16'hffff, 16'h00ab);
   endtask

   task automatic ot_refuse();
      logic [7:0] bad [4] = '{8'h00, 8'h40, 8'hc8, 8'hf8};
      foreach (bad[i]) begin
         host_u.wr(CMD_CLEAR_FAULTS, 8'h00);
         host_u.wr(CMD_OT_ACTION, bad[i]);
         rd_chk(CMD_STATUS_CML, 16'h0040, 16'h0040);
         rd_chk(CMD_OT_ACTION, 16'hffff, 16'h00c0);
      end
      host_u.wr(CMD_CLEAR_FAULTS, 8'h00);
      host_u.wr(CMD_OT_ACTION, 8'hc7);
      rd_chk(CMD_STATUS_CML, 16'h0040, 16'h0000);
   endtask

   task automatic oc_limit();
      setup(8'h00, 8'hc0);
      oc_detect = 1'b1;
      cycles(3);
      bit_chk(current_limit, 1'b1);
      cycles(20);
      bit_chk(output_enable, 1'b1);
      bit_chk(alert_oe, 1'b1);
      bit_chk(alert_out, 1'b0);
      rd_chk(CMD_STATUS_WORD, SW_MASK, 16'h4011);
      rd_chk(CMD_STATUS_IOUT, 16'h0080, 16'h0080);
      rd_chk(CMD_STATUS_BYTE, 16'h00ff, 16'h0011);
      oc_detect = 1'b0;
      cycles(2);
      bit_chk(current_limit, 1'b0);
      rd_chk(CMD_STATUS_WORD, SW_MASK, 16'h4011);
      host_u.wr(CMD_CLEAR_FAULTS, 8'h00);
      rd_chk(CMD_STATUS_WORD, SW_MASK, 16'h0000);
      bit_chk(alert_oe, 1'b0);
   endtask

   task automatic oc_deglitch();
      setup(8'h82, 8'hc0);
      oc_detect = 1'b1;
      cycles(12);
      bit_chk(output_enable, 1'b1);
      cycles(8);
      bit_chk(output_enable, 1'b0);
      tick();
      bit_chk(output_enable, 1'b0);
      oc_detect = 1'b0;
      operation_on = 1'b0;
      cycles(2);
      operation_on = 1'b1;
      cycles(3);
      bit_chk(output_enable, 1'b1);
      rd_chk(CMD_STATUS_WORD, SW_MASK, 16'h0000);
      setup(8'hb8, 8'hc0);
      oc_detect = 1'b1;
      cycles(3);
      bit_chk(output_enable, 1'b0);
      oc_detect = 1'b0;
      tick();
      bit_chk(output_enable, 1'b1);
   endtask

   task automatic oc_off_now();
      setup(8'hff, 8'hc0);
      for (int i = 0; i < 3; i++) begin
         oc_detect = 1'b1;
         cycles(3);
         bit_chk(output_enable, 1'b0);
         oc_detect = 1'b0;
         cycles(3);
         bit_chk(output_enable, 1'b0);
         tick();
         bit_chk(output_enable, 1'b1);
      end
   endtask

   task automatic ot_faults();
      setup(8'h00, 8'h80);
      ot_detect = 1'b1;
      cycles(3);
      bit_chk(output_enable, 1'b0);
      bit_chk(alert_oe, 1'b1);
      rd_chk(CMD_STATUS_WORD, SW_MASK, 16'h1001);
      rd_chk(CMD_STATUS_MFR, 16'h0040, 16'h0040);
      ot_detect = 1'b0;
      cycles(3);
      bit_chk(output_enable, 1'b0);
      setup(8'h00, 8'hc0);
      ot_detect = 1'b1;
      cycles(3);
      bit_chk(output_enable, 1'b0);
      ot_detect = 1'b0;
      cycles(3);
      bit_chk(output_enable, 1'b1);
   endtask

   // About 230 cycles of tests; cut off well beyond that
   initial begin
      #200_000;
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      cycles(4);
      rst_b = 1'b1;
      reg_defaults();
      ot_refuse();
      oc_limit();
      oc_deglitch();
      oc_off_now();
      ot_faults();
      tally_and_finish();
   end
endmodule
